// file: rtl/rnf_params.svh
`ifndef RNF_PARAMS_SVH
`define RNF_PARAMS_SVH
// Register offsets (byte addresses)
`define RNF_OFF_AHI_SET 12'h100
`define RNF_OFF_AHI_CLR 12'h104
`define RNF_OFF_ALO_SET 12'h108
`define RNF_OFF_ALO_CLR 12'h10C
`define RNF_OFF_PHI_SET 12'h110
`define RNF_OFF_PHI_CLR 12'h114
// Reset value of every filter register
`define RNF_FILT_RST 32'h0000_0000
// Position of the all-buses bit
`define RNF_ALL_BUS_BIT 31
// Node numbering
`define RNF_NODE_HI_BASE 6'h20
`define RNF_NODE_BCAST 6'h3F
`endif

// file: rtl/rnf_pkg.sv
package rnf_pkg;
  // Where an incoming request ends up
  typedef enum logic [1:0]
  {
    RNF_ROUTE_NOACK = 2'b00,
    RNF_ROUTE_ASYNC = 2'b01,
    RNF_ROUTE_PHYS = 2'b10
  } rnf_route_t;
  typedef logic [31:0] rnf_word_t;
  typedef logic [5:0] rnf_node_t;
endpackage

// file: rtl/rnf_filt_if.sv
`timescale 1ns/1ps
// Filter state and request towards the route decision
interface rnf_filt_if;
  import rnf_pkg::*;
  rnf_word_t async_low;
  rnf_word_t async_high;
  rnf_word_t phys_low;
  rnf_word_t phys_high;
  rnf_node_t node;
  logic remote;
  logic phys;
  rnf_route_t route;
  modport regs (output async_low, async_high, phys_low, phys_high, node, remote, phys,
    input route);
  modport decide (input async_low, async_high, phys_low, phys_high, node, remote, phys,
    output route);
endinterface

// file: rtl/rnf_decide.sv
`timescale 1ns/1ps
`include "rnf_params.svh"
// Route decision for one request, purely combinational
module rnf_decide
  import rnf_pkg::*;
(
  rnf_filt_if.decide f
);
  logic async_ok;
  logic phys_ok;

  // Per-node lookup, then remote-bus handling
  always_comb
  begin
    async_ok = 1'b0;
    phys_ok = 1'b0;
    f.route = RNF_ROUTE_NOACK;
    if (f.node < `RNF_NODE_HI_BASE)
    begin
      async_ok = f.async_low[f.node[4:0]];
      phys_ok = f.phys_low[f.node[4:0]];
    end
    else if (f.node != `RNF_NODE_BCAST)
    begin
      async_ok = f.async_high[f.node[4:0]];
      phys_ok = f.phys_high[f.node[4:0]];
    end
    if (f.remote)
    begin
      // No per-node compare for other buses; all-buses bit gates every kind
      if (f.phys_high[`RNF_ALL_BUS_BIT])
      begin
        f.route = f.phys ? RNF_ROUTE_PHYS : RNF_ROUTE_ASYNC;
      end
      else
      begin
        f.route = RNF_ROUTE_NOACK;
      end
    end
    else if (async_ok)
    begin
      // Physical requests pass the async check first
      if (f.phys && phys_ok)
      begin
        f.route = RNF_ROUTE_PHYS;
      end
      else
      begin
        f.route = RNF_ROUTE_ASYNC;
      end
    end
  end
endmodule

// file: rtl/rnf_top.sv
// Summary of operation
// - Async requests from nodes 0..31 accepted only if low filter bit set.
// - Low async filter has a set address and a clear address.
// - Low async filter behaves like the high async filter.
// - All filter bits are zero after power reset.
// - Physical requests pass the async filter, then the physical filter.
// - Physical filter bit clear sends request to async request context.
// - Per-node physical compare only for sources on the local bus.
// - Remote-bus packets are not acknowledged unless all-buses bit is set.
// - All-buses bit set accepts every request from remote buses.
// - All-buses bit survives host bus reset; other bits clear.
// - Physical high bits 30..0 map to nodes 62..32.
// - Physical high filter has its own set address.
// - High async bits 30..0 enable nodes 62..32.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "rnf_params.svh"
module rnf_top
  import rnf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwr_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [31:0] phys_filter_low,
  input wire logic req_valid,
  input wire logic [5:0] req_node,
  input wire logic req_remote,
  input wire logic req_phys,
  output logic dec_valid,
  output logic [5:0] dec_node,
  output rnf_route_t dec_route
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic wr_acc;
  logic setup;
  logic ahi_set;
  logic ahi_clr;
  logic alo_set;
  logic alo_clr;
  logic phi_set;
  logic phi_clr;
  logic map_hit;
  rnf_word_t async_low_r;
  rnf_word_t async_high_r;
  logic [30:0] phys_node_r;
  logic phys_all_r;
  rnf_word_t alo_nxt;
  rnf_word_t ahi_nxt;
  rnf_word_t phi_nxt;
  rnf_word_t prdata_r;
  logic pslverr_r;
  logic dec_valid_r;
  logic [5:0] dec_node_r;
  rnf_route_t dec_route_r;
  rnf_filt_if filt ();

  // Every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  // Write strobes per address
  assign ahi_set = wr_acc && (paddr == `RNF_OFF_AHI_SET);
  assign ahi_clr = wr_acc && (paddr == `RNF_OFF_AHI_CLR);
  assign alo_set = wr_acc && (paddr == `RNF_OFF_ALO_SET);
  assign alo_clr = wr_acc && (paddr == `RNF_OFF_ALO_CLR);
  assign phi_set = wr_acc && (paddr == `RNF_OFF_PHI_SET);
  assign phi_clr = wr_acc && (paddr == `RNF_OFF_PHI_CLR);

  // Address lands on one of the filter registers
  assign map_hit = (paddr == `RNF_OFF_AHI_SET) || (paddr == `RNF_OFF_AHI_CLR) ||
    (paddr == `RNF_OFF_ALO_SET) || (paddr == `RNF_OFF_ALO_CLR) ||
    (paddr == `RNF_OFF_PHI_SET) || (paddr == `RNF_OFF_PHI_CLR);

  ////////////////////////////////////////////////////////////////////////////
  // Set and clear per bit

  for (genvar i = 0; i < 32; i++)
  begin : g_bit
    // A one sets or clears, a zero leaves the bit
    assign alo_nxt[i] = (alo_set && pwdata[i]) ? 1'b1 :
      (alo_clr && pwdata[i]) ? 1'b0 : async_low_r[i];
    assign ahi_nxt[i] = (ahi_set && pwdata[i]) ? 1'b1 :
      (ahi_clr && pwdata[i]) ? 1'b0 : async_high_r[i];
    assign phi_nxt[i] = (phi_set && pwdata[i]) ? 1'b1 :
      (phi_clr && pwdata[i]) ? 1'b0 : ((i == 31) ? phys_all_r : phys_node_r[i % 31]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter registers

  // Low async filter, nodes 0 to 31
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_low_r <= `RNF_FILT_RST;
    end
    else
    begin
      async_low_r <= alo_nxt;
    end
  end

  // High async filter, nodes 32 to 62; bit 31 is unused, the all-buses bit is in the physical filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_high_r <= `RNF_FILT_RST;
    end
    else
    begin
      async_high_r <= ahi_nxt;
    end
  end

  // Physical node bits clear on host reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phys_node_r <= 31'h0000_0000;
    end
    else
    begin
      phys_node_r <= phi_nxt[30:0];
    end
  end

  // All-buses bit clears on power reset or a clear write, never on host reset
  always_ff @(posedge pclk or negedge pwr_rst_n)
  begin
    if (!pwr_rst_n)
    begin
      phys_all_r <= 1'b0;
    end
    else if (presetn)
    begin
      phys_all_r <= phi_nxt[`RNF_ALL_BUS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and error, loaded in the setup cycle

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_r <= 1'b0;
      case (paddr)
        `RNF_OFF_AHI_SET, `RNF_OFF_AHI_CLR:
        begin
          prdata_r <= async_high_r;
        end
        `RNF_OFF_ALO_SET, `RNF_OFF_ALO_CLR:
        begin
          prdata_r <= async_low_r;
        end
        `RNF_OFF_PHI_SET, `RNF_OFF_PHI_CLR:
        begin
          prdata_r <= {phys_all_r, phys_node_r};
        end
        default:
        begin
          prdata_r <= 32'h0000_0000;
          pslverr_r <= 1'b1;
        end
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Route decision

  assign filt.async_low = async_low_r;
  assign filt.async_high = async_high_r;
  assign filt.phys_low = phys_filter_low;
  assign filt.phys_high = {phys_all_r, phys_node_r};
  assign filt.node = req_node;
  assign filt.remote = req_remote;
  assign filt.phys = req_phys;

  rnf_decide u_decide (
    .f (filt.decide)
  );

  // Decision registered one cycle after the request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_valid_r <= 1'b0;
      dec_node_r <= 6'h00;
      dec_route_r <= RNF_ROUTE_NOACK;
    end
    else
    begin
      dec_valid_r <= req_valid;
      if (req_valid)
      begin
        dec_node_r <= req_node;
        dec_route_r <= filt.route;
      end
    end
  end

  assign dec_valid = dec_valid_r;
  assign dec_node = dec_node_r;
  assign dec_route = dec_route_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_req_local_low;
    req_valid && !req_remote && (req_node < `RNF_NODE_HI_BASE);
  endsequence

  sequence s_req_remote_phys;
    req_valid && req_remote && req_phys;
  endsequence

  sequence s_noack_out;
    dec_valid && (dec_route == RNF_ROUTE_NOACK);
  endsequence

  sequence s_req_remote_any;
    req_valid && req_remote;
  endsequence

  a_filter_reset_zero: assert property (
    @(posedge pclk) !presetn |-> (async_low_r == 32'h0000_0000) && (phys_node_r == 31'h0)
  ) else $error("filter bits not zero in reset");

  a_low_set_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    alo_set |=> ((async_low_r & $past(pwdata)) == $past(pwdata))
  ) else $error("set write did not set bits");

  a_low_clear_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    alo_clr |=> ((async_low_r & $past(pwdata)) == 32'h0000_0000)
  ) else $error("clear write did not clear bits");

  a_zero_write_none: assert property (
    @(posedge pclk) disable iff (!presetn)
    (alo_set || alo_clr) && (pwdata == 32'h0000_0000) |=> $stable(async_low_r)
  ) else $error("zero write changed the filter");

  a_all_bus_keep: assert property (
    @(posedge pclk) disable iff (!pwr_rst_n)
    !presetn |=> $stable(phys_all_r)
  ) else $error("all-buses bit lost in host reset");

  a_low_node_block: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_req_local_low ##0 !async_low_r[req_node[4:0]] |=> s_noack_out
  ) else $error("blocked node was accepted");

  a_remote_no_ack: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_req_remote_phys ##0 !phys_all_r |=> s_noack_out
  ) else $error("remote packet acknowledged");

  a_remote_all_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_req_remote_phys ##0 phys_all_r |=> dec_valid && (dec_route == RNF_ROUTE_PHYS)
  ) else $error("remote packet not accepted");

  a_phys_divert_async: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_req_local_low ##0 req_phys && async_low_r[req_node[4:0]]
      && !phys_filter_low[req_node[4:0]]
    |=> dec_valid && (dec_route == RNF_ROUTE_ASYNC)
  ) else $error("physical request not diverted");

  a_high_node_phys: assert property (
    @(posedge pclk) disable iff (!presetn)
    req_valid && !req_remote && req_phys && (req_node >= `RNF_NODE_HI_BASE)
      && (req_node != `RNF_NODE_BCAST) && async_high_r[req_node[4:0]]
      && phys_node_r[req_node[4:0]]
    |=> dec_valid && (dec_route == RNF_ROUTE_PHYS)
  ) else $error("high node not routed to physical");

  a_read_low_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && (paddr == `RNF_OFF_ALO_CLR) |-> prdata == async_low_r
  ) else $error("read data differs from filter");

  a_remote_any_block: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_req_remote_any ##0 !phys_all_r |=> s_noack_out
  ) else $error("remote request acknowledged without all-buses bit");

  a_remote_async_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_req_remote_any ##0 (!req_phys && phys_all_r)
    |=> dec_valid && (dec_route == RNF_ROUTE_ASYNC)
  ) else $error("remote async request not accepted");

  a_dec_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    req_valid |=> dec_valid && (dec_node == $past(req_node))
  ) else $error("decision missing or wrong node");

  a_dec_pulse_end: assert property (
    @(posedge pclk) disable iff (!presetn)
    !req_valid |=> !dec_valid
  ) else $error("decision without a request");

  a_bcast_reject: assert property (
    @(posedge pclk) disable iff (!presetn)
    req_valid && !req_remote && (req_node == `RNF_NODE_BCAST) |=> s_noack_out
  ) else $error("node 63 was accepted");

  a_high_set_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    phi_set |=> (({phys_all_r, phys_node_r} & $past(pwdata)) == $past(pwdata))
  ) else $error("physical set write did not set bits");

  a_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable |-> (pslverr == !map_hit)
  ) else $error("error flag wrong for address");

  a_host_reset_clear: assert property (
    @(posedge pclk) !presetn |-> (async_high_r == 32'h0000_0000) && (phys_node_r == 31'h0)
  ) else $error("host reset left filter bits set");

endmodule

// file: sim/rnf_node_model.sv
`timescale 1ns/1ps
// Node that issues one local or remote request per call
module rnf_node_model
  import rnf_pkg::*;
(
  input wire logic pclk,
  output logic req_valid,
  output rnf_node_t req_node,
  output logic req_remote,
  output logic req_phys
);
  // Idle lines at time zero
  initial
  begin
    req_valid = 1'b0;
    req_node = 6'h00;
    req_remote = 1'b0;
    req_phys = 1'b0;
  end
  // One-cycle request; afterwards the lines show the inverse of their last value
  task automatic send(input rnf_node_t n, input logic rem, input logic ph);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_node <= n;
    req_remote <= rem;
    req_phys <= ph;
    @(posedge pclk);
    req_valid <= 1'b0;
    req_node <= ~n;
    req_remote <= ~rem;
    req_phys <= ~ph;
  endtask
endmodule

// file: sim/request_node_filter_tb.sv
`timescale 1ns/1ps
module request_node_filter_tb;
  import rnf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic pwr_rst_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] phys_filter_low = 32'h0000_0000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic req_valid;
  rnf_node_t req_node;
  logic req_remote;
  logic req_phys;
  logic dec_valid;
  rnf_node_t dec_node;
  rnf_route_t dec_route;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int check_count = 0;
  always #12.5 pclk = ~pclk;
  rnf_top u_rnf_top (.pclk, .presetn, .pwr_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .phys_filter_low, .req_valid, .req_node, .req_remote,
    .req_phys, .dec_valid, .dec_node, .dec_route);
  rnf_node_model u_rnf_node_model (.pclk, .req_valid, .req_node, .req_remote, .req_phys);
  ////////////////////////////////////////////////////////////////////////
  // APB transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compare a word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  // Send a request and compare the decision one cycle later
  task automatic chk_req(input rnf_node_t n, input logic rem, input logic ph,
    input rnf_route_t exp);
    u_rnf_node_model.send(n, rem, ph);
    #1;
    check_count++;
    if (dec_valid !== 1'b1 || dec_route !== exp || dec_node !== n)
    begin
      fail_count++;
      $display("[FAIL] %0t node %0d route %b expected %b", $time, n, dec_route, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset values and set/clear behaviour of the low async filter
  task automatic t_set_clear();
    apb(1'b0, 12'h108, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b0, 12'h110, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b1, 12'h108, 32'hA5A5_0F0F);
    apb(1'b1, 12'h108, 32'h0000_0000);
    apb(1'b1, 12'h10C, 32'h0000_0F00);
    apb(1'b0, 12'h10C, 32'h0);
    chk_word(rd, 32'hA5A5_000F);
    chk_word({31'h0, err}, 32'h0000_0000);
    apb(1'b1, 12'h10C, 32'hFFFF_FFFF);
  endtask
  // Local low nodes: async accept and physical recheck
  task automatic t_low_nodes();
    apb(1'b1, 12'h108, 32'h8000_0021);
    phys_filter_low <= 32'h0000_0020;
    chk_req(6'h05, 1'b0, 1'b0, RNF_ROUTE_ASYNC);
    chk_req(6'h06, 1'b0, 1'b0, RNF_ROUTE_NOACK);
    chk_req(6'h1F, 1'b0, 1'b0, RNF_ROUTE_ASYNC);
    chk_req(6'h05, 1'b0, 1'b1, RNF_ROUTE_PHYS);
    chk_req(6'h00, 1'b0, 1'b1, RNF_ROUTE_ASYNC);
    chk_req(6'h06, 1'b0, 1'b1, RNF_ROUTE_NOACK);
  endtask
  // Local high nodes through both high filters
  task automatic t_high_nodes();
    apb(1'b1, 12'h100, 32'h4000_000C);
    apb(1'b1, 12'h110, 32'h4000_0004);
    apb(1'b0, 12'h110, 32'h0);
    chk_word(rd, 32'h4000_0004);
    chk_req(6'h22, 1'b0, 1'b1, RNF_ROUTE_PHYS);
    chk_req(6'h23, 1'b0, 1'b1, RNF_ROUTE_ASYNC);
    chk_req(6'h3E, 1'b0, 1'b1, RNF_ROUTE_PHYS);
    chk_req(6'h21, 1'b0, 1'b0, RNF_ROUTE_NOACK);
    chk_req(6'h23, 1'b0, 1'b0, RNF_ROUTE_ASYNC);
    apb(1'b1, 12'h114, 32'h0000_0004);
    chk_req(6'h22, 1'b0, 1'b1, RNF_ROUTE_ASYNC);
    apb(1'b1, 12'h104, 32'h0000_0008);
    apb(1'b0, 12'h100, 32'h0);
    chk_word(rd, 32'h4000_0004);
    chk_req(6'h23, 1'b0, 1'b0, RNF_ROUTE_NOACK);
  endtask
  // Remote sources and the all-buses bit across a host reset
  task automatic t_remote();
    chk_req(6'h22, 1'b1, 1'b1, RNF_ROUTE_NOACK);
    apb(1'b1, 12'h100, 32'h8000_0000);
    chk_req(6'h05, 1'b1, 1'b0, RNF_ROUTE_NOACK);
    chk_req(6'h3F, 1'b0, 1'b0, RNF_ROUTE_NOACK);
    apb(1'b1, 12'h110, 32'h8000_0000);
    chk_req(6'h05, 1'b1, 1'b1, RNF_ROUTE_PHYS);
    chk_req(6'h23, 1'b1, 1'b1, RNF_ROUTE_PHYS);
    chk_req(6'h05, 1'b1, 1'b0, RNF_ROUTE_ASYNC);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h110, 32'h0);
    chk_word(rd, 32'h8000_0000);
    apb(1'b0, 12'h108, 32'h0);
    chk_word(rd, 32'h0000_0000);
    chk_req(6'h05, 1'b0, 1'b0, RNF_ROUTE_NOACK);
  endtask
  // Unmapped address reads zero with an error
  task automatic t_unmapped();
    apb(1'b1, 12'h120, 32'hFFFF_FFFF);
    apb(1'b0, 12'h120, 32'h0);
    chk_word(rd, 32'h0000_0000);
    chk_word({31'h0, err}, 32'h0000_0001);
    chk_word({31'h0, pready}, 32'h0000_0001);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    // Both resets fall at time zero so the reset branches see an edge
    presetn <= 1'b0;
    pwr_rst_n <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    pwr_rst_n <= 1'b1;
    t_set_clear();
    t_low_nodes();
    t_high_nodes();
    t_remote();
    t_unmapped();
    close_out();
  end
  // Watchdog
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule
